/* File: rtl/hqpe_params.svh */
// Purpose: constants of the queue pair engine
// Assumes: one clock, no software registers
// Notes: ring counts are small; index and id widths reach 64K
`ifndef HQPE_PARAMS_SVH
`define HQPE_PARAMS_SVH
`define HQPE_IDX_W 16
`define HQPE_ID_W 16
`define HQPE_NCMD 4
`define HQPE_CSEL_W 2
`define HQPE_NRES 2
`define HQPE_RSEL_W 1
`define HQPE_CMD_SHIFT 6
`define HQPE_STAT_W 15
`define HQPE_ADMIN_ID 16'h0000
`define HQPE_PP_INLINE 16'h0002
`define HQPE_PHASE_INIT 1'b1
`define HQPE_ERR_W 4
`define HQPE_ERR_DB 0
`define HQPE_ERR_CPL 1
`define HQPE_ERR_USED 4'h3
`endif

/* File: rtl/hqpe_pkg.sv */
// Purpose: types and shared helpers of the queue pair engine
// Assumes: constants come from the params header
// Notes: ring indices are full 16-bit for 64K slots
`include "hqpe_params.svh"
package hqpe_pkg;
   typedef logic [`HQPE_IDX_W-1:0] hqpe_idx_type;
   typedef enum logic [1:0] {HQPE_F_IDLE = 2'h1, HQPE_F_REQ = 2'h2} hqpe_fetch_type;
   typedef struct packed {
      logic valid;
      hqpe_idx_type size_z;
      hqpe_idx_type head;
      hqpe_idx_type tail;
      logic [`HQPE_RSEL_W-1:0] res_id;
   } hqpe_cmd_ring_type;
   typedef struct packed {
      logic valid;
      hqpe_idx_type size_z;
      hqpe_idx_type head;
      hqpe_idx_type tail;
      logic phase;
   } hqpe_res_ring_type;
   typedef struct packed {
      logic [`HQPE_RSEL_W-1:0] res_id;
      logic [`HQPE_ID_W-1:0] cr_id;
      hqpe_idx_type cr_head;
      logic [15:0] cmd_id;
      logic [`HQPE_STAT_W-1:0] status;
   } hqpe_entry_type;
   // next slot, wrapping after the last one (size is zero-based)
   function automatic hqpe_idx_type hqpe_next(input hqpe_idx_type i, input hqpe_idx_type last);
      return (i == last) ? '0 : i + 16'h0001;
   endfunction
   function automatic logic hqpe_full(input hqpe_idx_type t, input hqpe_idx_type h,
                                      input hqpe_idx_type last);
      return hqpe_next(t, last) == h;
   endfunction
   function automatic logic hqpe_id_ok(input logic [15:0] id, input logic [15:0] n);
      return id < n;
   endfunction
endpackage

/* File: rtl/hqpe_post_if.sv */
// Purpose: link between fetch side and result poster
// Assumes: both ends on one clock
// Notes: ack and drop are same-cycle answers to req
`timescale 1ns/1ps
`include "hqpe_params.svh"
interface hqpe_post_if;
   logic cfg_wr;
   logic cfg_en;
   logic [`HQPE_ID_W-1:0] cfg_id;
   hqpe_pkg::hqpe_idx_type cfg_size_z;
   logic db_wr;
   logic [`HQPE_ID_W-1:0] db_id;
   hqpe_pkg::hqpe_idx_type db_val;
   logic db_err;
   logic req;
   hqpe_pkg::hqpe_entry_type ent;
   logic ack;
   logic drop;
   logic post_valid;
   logic post_ready;
   hqpe_pkg::hqpe_entry_type post_ent;
   hqpe_pkg::hqpe_idx_type post_slot;
   logic post_phase;
   modport top (output cfg_wr, cfg_en, cfg_id, cfg_size_z, db_wr, db_id, db_val, req, ent,
                post_ready, input db_err, ack, drop, post_valid, post_ent, post_slot, post_phase);
   modport post (input cfg_wr, cfg_en, cfg_id, cfg_size_z, db_wr, db_id, db_val, req, ent,
                 post_ready, output db_err, ack, drop, post_valid, post_ent, post_slot,
                 post_phase);
endinterface

/* File: rtl/hqpe_result_post.sv */
// Purpose: result rings: head, tail, phase and entry posting
// Assumes: one entry at a time; poster stalls while ring is full
// Notes: entry is held until the memory writer takes it
`timescale 1ns/1ps
`include "hqpe_params.svh"
module hqpe_result_post (
   input wire logic clk,
   input wire logic rst_n,
   hqpe_post_if.post pif
);
   typedef struct packed {
      hqpe_pkg::hqpe_res_ring_type [`HQPE_NRES-1:0] rr;
      logic pvalid;
      hqpe_pkg::hqpe_entry_type pent;
      hqpe_pkg::hqpe_idx_type pslot;
      logic pphase;
   } hqpe_post_state_type;
   hqpe_post_state_type st_q;
   hqpe_post_state_type st_d;
   logic ack_c;
   logic drop_c;
   logic derr_c;
   hqpe_pkg::hqpe_res_ring_type r;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      st_d = st_q;
      ack_c = 1'b0;
      drop_c = 1'b0;
      derr_c = 1'b0;
      r = st_q.rr[pif.ent.res_id];
      if (st_q.pvalid && pif.post_ready) begin
         st_d.pvalid = 1'b0;
      end
      // result ring picked by the entry's res_id: entries from every command ring mapped to it land here
      if (pif.req) begin
         if (!r.valid) begin
            drop_c = 1'b1;
         end else if (!st_d.pvalid && !hqpe_pkg::hqpe_full(r.tail, r.head, r.size_z)) begin
            ack_c = 1'b1;
            st_d.pvalid = 1'b1;
            st_d.pent = pif.ent;
            st_d.pslot = r.tail;
            st_d.pphase = r.phase;
            st_d.rr[pif.ent.res_id].tail = hqpe_pkg::hqpe_next(r.tail, r.size_z);
            if (r.tail == r.size_z) begin
               st_d.rr[pif.ent.res_id].phase = ~r.phase;
            end
         end
      end
      // host frees slots by moving head
      if (pif.db_wr) begin
         if (hqpe_pkg::hqpe_id_ok(pif.db_id, 16'(`HQPE_NRES))
             && st_q.rr[pif.db_id[`HQPE_RSEL_W-1:0]].valid
             && pif.db_val <= st_q.rr[pif.db_id[`HQPE_RSEL_W-1:0]].size_z) begin
            st_d.rr[pif.db_id[`HQPE_RSEL_W-1:0]].head = pif.db_val;
         end else begin
            derr_c = 1'b1;
         end
      end
      // creation restarts indices and phase
      if (pif.cfg_wr && hqpe_pkg::hqpe_id_ok(pif.cfg_id, 16'(`HQPE_NRES))) begin
         st_d.rr[pif.cfg_id[`HQPE_RSEL_W-1:0]].valid = pif.cfg_en;
         st_d.rr[pif.cfg_id[`HQPE_RSEL_W-1:0]].size_z = pif.cfg_size_z;
         st_d.rr[pif.cfg_id[`HQPE_RSEL_W-1:0]].head = '0;
         st_d.rr[pif.cfg_id[`HQPE_RSEL_W-1:0]].tail = '0;
         st_d.rr[pif.cfg_id[`HQPE_RSEL_W-1:0]].phase = `HQPE_PHASE_INIT;
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign pif.ack = ack_c;
   assign pif.drop = drop_c;
   assign pif.db_err = derr_c;
   assign pif.post_valid = st_q.pvalid;
   assign pif.post_ent = st_q.pent;
   assign pif.post_slot = st_q.pslot;
   assign pif.post_phase = st_q.pphase;

   // ****************************************
   // checks
   // ****************************************
   default clocking cbp @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_take_last;
      ack_c && r.tail == r.size_z && !pif.cfg_wr;
   endsequence
   a_phase_wrap: assert property (s_take_last |=> st_q.rr[$past(pif.ent.res_id)].phase
      == !$past(r.phase)) else $error("phase not inverted at wrap");
   a_no_full: assert property (ack_c |-> !hqpe_pkg::hqpe_full(r.tail, r.head, r.size_z))
      else $error("entry posted into full ring");
   a_create_phase: assert property (pif.cfg_wr && pif.cfg_en && pif.cfg_id == 16'h0000
      |=> st_q.rr[0].phase && st_q.rr[0].tail == 16'h0000)
      else $error("new ring phase not one");
   a_post_hold: assert property (st_q.pvalid && !pif.post_ready |=> st_q.pvalid
      && $stable(st_q.pslot) && $stable(st_q.pent)) else $error("entry lost");
endmodule

/* File: rtl/hqpe_top.sv */
// Purpose: queue pair engine: command ring fetch, completion routing
// Assumes: all inputs come from bus logic on REF_CLK
// Notes: host memory traffic is done outside by fetch and post movers
`timescale 1ns/1ps
`include "hqpe_params.svh"
module hqpe_top #(
   parameter bit FORCE_OK = 1'b0
) (
   input wire logic REF_CLK,
   input wire logic RESET_N,
   input wire logic DB_WR,
   input wire logic DB_IS_HEAD,
   input wire logic [`HQPE_ID_W-1:0] DB_RING_ID,
   input wire logic [`HQPE_IDX_W-1:0] DB_VALUE,
   input wire logic CFG_WR,
   input wire logic CFG_IS_RES,
   input wire logic CFG_EN,
   input wire logic [`HQPE_ID_W-1:0] CFG_ID,
   input wire logic [`HQPE_IDX_W-1:0] CFG_SIZE_Z,
   input wire logic [`HQPE_ID_W-1:0] CFG_RES_ID,
   output logic FETCH_VALID,
   input wire logic FETCH_READY,
   output logic [`HQPE_ID_W-1:0] FETCH_RING_ID,
   output logic [`HQPE_IDX_W-1:0] FETCH_SLOT,
   output logic [`HQPE_IDX_W+`HQPE_CMD_SHIFT-1:0] FETCH_BYTE_OFS,
   input wire logic FETCH_DATA_VALID,
   input wire logic [15:0] FETCH_NPAGES,
   output logic PAGE_LIST_USED,
   input wire logic CPL_REQ,
   output logic CPL_READY,
   input wire logic [`HQPE_ID_W-1:0] CPL_RING_ID,
   input wire logic [15:0] CPL_CMD_ID,
   input wire logic [`HQPE_STAT_W-1:0] CPL_STATUS,
   output logic POST_VALID,
   input wire logic POST_READY,
   output logic [`HQPE_RSEL_W-1:0] POST_RES_ID,
   output logic [`HQPE_IDX_W-1:0] POST_SLOT,
   output logic POST_PHASE,
   output logic [`HQPE_ID_W-1:0] POST_CR_ID,
   output logic [`HQPE_IDX_W-1:0] POST_CR_HEAD,
   output logic [15:0] POST_CMD_ID,
   output logic [`HQPE_STAT_W-1:0] POST_STATUS,
   input wire logic [`HQPE_ERR_W-1:0] ERR_CLR,
   input wire logic [`HQPE_ERR_W-1:0] ERR_SET,
   output logic [`HQPE_ERR_W-1:0] ERR_FLAGS
);
   typedef struct packed {
      hqpe_pkg::hqpe_fetch_type fs;
      hqpe_pkg::hqpe_cmd_ring_type [`HQPE_NCMD-1:0] cr;
      logic [`HQPE_CSEL_W-1:0] rr;
      logic [`HQPE_CSEL_W-1:0] fring;
      logic fvalid;
      hqpe_pkg::hqpe_idx_type fslot;
      logic pp_list;
      logic pend;
      hqpe_pkg::hqpe_entry_type ent;
      logic cpl_rdy;
      logic [`HQPE_ERR_W-1:0] err;
   } hqpe_top_state_type;

   hqpe_top_state_type st_q;
   hqpe_top_state_type st_d;
   logic [`HQPE_ERR_W-1:0] es;
   logic tdb_ok;
   logic cpl_ok;
   logic [`HQPE_CSEL_W-1:0] tsel;
   logic [`HQPE_CSEL_W-1:0] csel;
   logic [`HQPE_CSEL_W-1:0] ksel;

   hqpe_post_if pif ();

   // ****************************************
   // decode of ring ids
   // ****************************************
   // ids above the built rings are refused
   assign tsel = DB_RING_ID[`HQPE_CSEL_W-1:0];
   assign csel = CFG_ID[`HQPE_CSEL_W-1:0];
   assign ksel = CPL_RING_ID[`HQPE_CSEL_W-1:0];
   assign tdb_ok = hqpe_pkg::hqpe_id_ok(DB_RING_ID, 16'(`HQPE_NCMD)) && st_q.cr[tsel].valid
      && DB_VALUE <= st_q.cr[tsel].size_z;
   assign cpl_ok = hqpe_pkg::hqpe_id_ok(CPL_RING_ID, 16'(`HQPE_NCMD)) && st_q.cr[ksel].valid;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      int j;
      logic hit;
      j = 0;
      hit = 1'b0;
      st_d = st_q;
      es = '0;

      // single write submits: new tail overwrites old
      if (DB_WR && !DB_IS_HEAD) begin
         if (tdb_ok) begin
            st_d.cr[tsel].tail = DB_VALUE;
         end else begin
            es[`HQPE_ERR_DB] = 1'b1;
         end
      end
      if (pif.db_err) begin
         es[`HQPE_ERR_DB] = 1'b1;
      end

      // fetch arbiter: oldest slot of a ring first
      unique case (st_q.fs)
         hqpe_pkg::HQPE_F_IDLE: begin
            for (int i = 0; i < `HQPE_NCMD; i++) begin
               j = (int'(st_q.rr) + i) % `HQPE_NCMD;
               // slots between head and tail are submitted
               if (!hit && st_q.cr[j].valid && st_q.cr[j].head != st_q.cr[j].tail) begin
                  hit = 1'b1;
                  st_d.fring = `HQPE_CSEL_W'(j);
               end
            end
            if (hit) begin
               st_d.fvalid = 1'b1;
               st_d.fslot = st_q.cr[st_d.fring].head;
               st_d.fs = hqpe_pkg::HQPE_F_REQ;
            end
         end
         hqpe_pkg::HQPE_F_REQ: begin
            if (FETCH_READY) begin
               // head wraps after the last slot
               st_d.cr[st_q.fring].head = hqpe_pkg::hqpe_next(st_q.fslot,
                  st_q.cr[st_q.fring].size_z);
               st_d.fvalid = 1'b0;
               st_d.rr = st_q.fring + `HQPE_CSEL_W'(1);
               st_d.fs = hqpe_pkg::HQPE_F_IDLE;
            end
         end
      endcase

      // second pointer names a list when pages exceed two
      if (FETCH_DATA_VALID) begin
         st_d.pp_list = FETCH_NPAGES > `HQPE_PP_INLINE;
      end

      // completion waits until its entry is taken by the poster or dropped
      if (st_q.pend && (pif.ack || pif.drop)) begin
         st_d.pend = 1'b0;
      end
      if (pif.drop) begin
         es[`HQPE_ERR_CPL] = 1'b1;
      end
      if (CPL_REQ && st_q.cpl_rdy) begin
         if (cpl_ok) begin
            st_d.pend = 1'b1;
            st_d.ent.res_id = st_q.cr[ksel].res_id;
            st_d.ent.cr_id = CPL_RING_ID;
            st_d.ent.cr_head = st_d.cr[ksel].head;
            st_d.ent.cmd_id = CPL_CMD_ID;
            st_d.ent.status = CPL_STATUS;
         end else begin
            es[`HQPE_ERR_CPL] = 1'b1;
         end
      end
      st_d.cpl_rdy = !st_d.pend;

      // ring creation last so that it wins over fetch and doorbell
      if (CFG_WR && !CFG_IS_RES) begin
         if (hqpe_pkg::hqpe_id_ok(CFG_ID, 16'(`HQPE_NCMD))
             && hqpe_pkg::hqpe_id_ok(CFG_RES_ID, 16'(`HQPE_NRES))) begin
            st_d.cr[csel].valid = CFG_EN;
            st_d.cr[csel].size_z = CFG_SIZE_Z;
            st_d.cr[csel].head = '0;
            st_d.cr[csel].tail = '0;
            // ids from one upward are io rings
            // admin command ring always feeds admin result ring
            st_d.cr[csel].res_id = (CFG_ID == `HQPE_ADMIN_ID) ? '0
               : CFG_RES_ID[`HQPE_RSEL_W-1:0];
         end else begin
            es[`HQPE_ERR_DB] = 1'b1;
         end
      end

      // sticky flags: clear by one, set by one only if supported
      st_d.err = st_q.err & ~ERR_CLR;
      if (FORCE_OK) begin
         st_d.err = st_d.err | ERR_SET;
      end
      // an event in the clearing cycle still lands
      st_d.err = (st_d.err | es) & `HQPE_ERR_USED;
   end

   // state register
   always_ff @(posedge REF_CLK) begin
      if (!RESET_N) begin
         st_q <= '0;
         st_q.fs <= hqpe_pkg::HQPE_F_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // ****************************************
   // result poster
   // ****************************************
   assign pif.cfg_wr = CFG_WR && CFG_IS_RES;
   assign pif.cfg_en = CFG_EN;
   assign pif.cfg_id = CFG_ID;
   assign pif.cfg_size_z = CFG_SIZE_Z;
   assign pif.db_wr = DB_WR && DB_IS_HEAD;
   assign pif.db_id = DB_RING_ID;
   assign pif.db_val = DB_VALUE;
   assign pif.req = st_q.pend;
   assign pif.ent = st_q.ent;
   assign pif.post_ready = POST_READY;

   hqpe_result_post u_post (
      .clk(REF_CLK),
      .rst_n(RESET_N),
      .pif(pif.post)
   );

   // outputs, all from flops
   assign FETCH_VALID = st_q.fvalid;
   assign FETCH_RING_ID = `HQPE_ID_W'(st_q.fring);
   assign FETCH_SLOT = st_q.fslot;
   assign FETCH_BYTE_OFS = {st_q.fslot, `HQPE_CMD_SHIFT'(0)};
   assign PAGE_LIST_USED = st_q.pp_list;
   assign CPL_READY = st_q.cpl_rdy;
   assign POST_VALID = pif.post_valid;
   assign POST_RES_ID = pif.post_ent.res_id;
   assign POST_SLOT = pif.post_slot;
   assign POST_PHASE = pif.post_phase;
   assign POST_CR_ID = pif.post_ent.cr_id;
   assign POST_CR_HEAD = pif.post_ent.cr_head;
   assign POST_CMD_ID = pif.post_ent.cmd_id;
   assign POST_STATUS = pif.post_ent.status;
   assign ERR_FLAGS = st_q.err;

   // ****************************************
   // checks
   // ****************************************
   default clocking cbt @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);
   sequence s_fetch_hs;
      FETCH_VALID && FETCH_READY && !CFG_WR;
   endsequence
   sequence s_cpl_take;
      CPL_REQ && CPL_READY && cpl_ok;
   endsequence
   a_fetch_hold: assert property (FETCH_VALID && !FETCH_READY |=> FETCH_VALID
      && $stable(FETCH_SLOT) && $stable(FETCH_RING_ID))
      else $error("fetch withdrawn before taken");
   a_fetch_adv: assert property (s_fetch_hs |=> st_q.cr[$past(st_q.fring)].head
      == hqpe_pkg::hqpe_next($past(FETCH_SLOT), st_q.cr[$past(st_q.fring)].size_z))
      else $error("head not advanced in order");
   a_tail_db: assert property (DB_WR && !DB_IS_HEAD && tdb_ok && !CFG_WR
      |=> st_q.cr[$past(tsel)].tail == $past(DB_VALUE))
      else $error("tail not replaced");
   a_fetch_ofs: assert property (FETCH_VALID |-> FETCH_BYTE_OFS[5:0] == 6'h00
      && FETCH_BYTE_OFS[`HQPE_IDX_W+5:6] == FETCH_SLOT)
      else $error("slot offset wrong");
   a_err_w1c: assert property (ERR_FLAGS[0] && ERR_CLR[0] && !es[0] && !(FORCE_OK && ERR_SET[0])
      |=> !ERR_FLAGS[0]) else $error("flag not cleared");
   a_err_set: assert property (es[0] ##1 1'b1 |-> ERR_FLAGS[0])
      else $error("event lost");
   a_rsvd_zero: assert property (ERR_FLAGS[3:2] == 2'h0)
      else $error("reserved flag bits set");
   a_cpl_pend: assert property (s_cpl_take |=> !CPL_READY && pif.req
      && pif.ent.cmd_id == $past(CPL_CMD_ID)) else $error("completion not held");
endmodule

/* File: testbench/hqpe_host_model.sv */
// Purpose: host side model, answers command fetches and takes posted entries
// Assumes: one clock; stalls are paced by the slow input
// Notes: page count handed back is slot plus one, so list use is predictable
`timescale 1ns/1ps
module hqpe_host_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_slot,
   output logic fetch_ready,
   output logic fetch_data_valid,
   output logic [15:0] fetch_npages,
   input wire logic post_valid,
   output logic post_ready
);
   logic [1:0] wait_q;
   // ready pulses, data return; released count lines toggle each cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wait_q <= 2'h0;
         fetch_ready <= 1'b0;
         fetch_data_valid <= 1'b0;
         fetch_npages <= 16'h0000;
         post_ready <= 1'b0;
      end else begin
         wait_q <= wait_q + 2'h1;
         fetch_ready <= fetch_valid && !fetch_ready && (!slow || wait_q == 2'h3);
         fetch_data_valid <= fetch_valid && fetch_ready;
         // page count of the taken slot, else the released lines invert
         fetch_npages <= (fetch_valid && fetch_ready) ? fetch_slot + 16'h0001
            : ~fetch_npages;
         post_ready <= post_valid && !post_ready && (!slow || wait_q[0]);
      end
   end
endmodule

/* File: testbench/tb_hqpe_top.sv */
// Purpose: self-checking bench of the queue pair engine
// Assumes: host model answers fetches and posts
// Notes: random completions spread over three command rings
`timescale 1ns/1ps
module tb_hqpe_top;
   logic REF_CLK, RESET_N, DB_WR, DB_IS_HEAD, CFG_WR, CFG_IS_RES, CFG_EN, FETCH_VALID;
   logic FETCH_READY, FETCH_DATA_VALID, PAGE_LIST_USED, CPL_REQ, CPL_READY, POST_VALID;
   logic POST_READY, POST_PHASE, POST_RES_ID, slow;
   logic [15:0] DB_RING_ID, DB_VALUE, CFG_ID, CFG_SIZE_Z, CFG_RES_ID, FETCH_RING_ID, FETCH_SLOT;
   logic [15:0] FETCH_NPAGES, CPL_RING_ID, CPL_CMD_ID, POST_SLOT, POST_CR_ID, POST_CR_HEAD;
   logic [15:0] POST_CMD_ID;
   logic [21:0] FETCH_BYTE_OFS;
   logic [14:0] CPL_STATUS, POST_STATUS;
   logic [3:0] ERR_CLR, ERR_SET, ERR_FLAGS;
   logic [53:0] fq[$];
   logic [15:0] rtail[2];
   logic [15:0] rsz[2];
   logic rph[2];
   int failures, n_tests, k;
   int seed = 32'h0098ED7F;

   hqpe_top #(.FORCE_OK(1'b0)) u_hqpe_top (.REF_CLK, .RESET_N, .DB_WR, .DB_IS_HEAD, .DB_RING_ID,
      .DB_VALUE, .CFG_WR, .CFG_IS_RES, .CFG_EN, .CFG_ID, .CFG_SIZE_Z, .CFG_RES_ID, .FETCH_VALID,
      .FETCH_READY, .FETCH_RING_ID, .FETCH_SLOT, .FETCH_BYTE_OFS, .FETCH_DATA_VALID,
      .FETCH_NPAGES, .PAGE_LIST_USED, .CPL_REQ, .CPL_READY, .CPL_RING_ID, .CPL_CMD_ID,
      .CPL_STATUS, .POST_VALID, .POST_READY, .POST_RES_ID, .POST_SLOT, .POST_PHASE,
      .POST_CR_ID, .POST_CR_HEAD, .POST_CMD_ID, .POST_STATUS, .ERR_CLR, .ERR_SET, .ERR_FLAGS);

   hqpe_host_model u_hqpe_host_model (.clk(REF_CLK), .rst_n(RESET_N), .slow(slow),
      .fetch_valid(FETCH_VALID), .fetch_slot(FETCH_SLOT), .fetch_ready(FETCH_READY),
      .fetch_data_valid(FETCH_DATA_VALID), .fetch_npages(FETCH_NPAGES),
      .post_valid(POST_VALID), .post_ready(POST_READY));

   // ************************************
   // clock and fetch monitor
   // ************************************
   initial begin
      REF_CLK = 1'b0;
      forever #20 REF_CLK = ~REF_CLK;
   end
   // a fetch seen with ready at the falling edge is taken at the next rise
   always @(negedge REF_CLK) begin
      if (FETCH_VALID && FETCH_READY) fq.push_back({FETCH_RING_ID, FETCH_SLOT, FETCH_BYTE_OFS});
   end

   // ************************************
   // tasks
   // ************************************
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   // a wait that ran out ends the run
   task automatic bound(input int i);
      if (i >= 100) begin
         failures++;
         give_verdict();
      end
   endtask
   task automatic cfg(input logic is_res, input logic [15:0] id, sz, res);
      @(negedge REF_CLK);
      {CFG_WR, CFG_IS_RES, CFG_EN} = {1'b1, is_res, 1'b1};
      {CFG_ID, CFG_SIZE_Z, CFG_RES_ID} = {id, sz, res};
      @(negedge REF_CLK);
      CFG_WR = 1'b0;
   endtask
   task automatic db(input logic is_head, input logic [15:0] id, val);
      @(negedge REF_CLK);
      {DB_WR, DB_IS_HEAD, DB_RING_ID, DB_VALUE} = {1'b1, is_head, id, val};
      @(negedge REF_CLK);
      DB_WR = 1'b0;
   endtask
   task automatic fetch_chk(input logic [15:0] ring, slot);
      int i;
      for (i = 0; i < 100 && fq.size() == 0; i++) @(negedge REF_CLK);
      bound(i);
      cmp(fq.pop_front(), {ring, slot, slot, 6'h00});
   endtask
   // completion; for rings 0 to 2 the posted entry is checked and the host frees it, above ring 2 no post and the error flag are checked
   task automatic cpl(input logic [15:0] ring, id, input logic [14:0] st);
      int i;
      int r;
      @(negedge REF_CLK);
      for (i = 0; i < 100 && CPL_READY !== 1'b1; i++) @(negedge REF_CLK);
      bound(i);
      {CPL_REQ, CPL_RING_ID, CPL_CMD_ID, CPL_STATUS} = {1'b1, ring, id, st};
      @(negedge REF_CLK);
      CPL_REQ = 1'b0;
      r = (ring == 16'h0000) ? 0 : 1;
      if (ring > 16'h0002) begin
         repeat (4) @(negedge REF_CLK);
         cmp({POST_VALID, ERR_FLAGS}, 5'h02);
      end else begin
         for (i = 0; i < 100 && !(POST_VALID && POST_READY); i++) @(negedge REF_CLK);
         bound(i);
         cmp(POST_RES_ID, r);
         cmp(POST_SLOT, rtail[r]);
         cmp(POST_PHASE, rph[r]);
         cmp({POST_CR_ID, POST_CR_HEAD}, {ring, 16'h0000});
         cmp({POST_CMD_ID, POST_STATUS}, {id, st});
         if (rtail[r] == rsz[r]) begin
            rtail[r] = 16'h0000;
            rph[r] = ~rph[r];
         end else begin
            rtail[r] = rtail[r] + 16'h0001;
         end
         db(1'b1, r[15:0], rtail[r]);
      end
   endtask

   // ************************************
   // main sequence
   // ************************************
   initial begin
      {RESET_N, DB_WR, DB_IS_HEAD, CFG_WR, CFG_IS_RES, CFG_EN, CPL_REQ, slow} = 8'h00;
      {DB_RING_ID, DB_VALUE, CFG_ID, CFG_SIZE_Z, CFG_RES_ID} = '0;
      {CPL_RING_ID, CPL_CMD_ID, CPL_STATUS, ERR_CLR, ERR_SET} = '0;
      rsz = '{16'h0002, 16'h0003};
      rtail = '{16'h0000, 16'h0000};
      rph = '{1'b1, 1'b1};
      repeat (12) @(negedge REF_CLK);
      cmp({FETCH_VALID, CPL_READY, POST_VALID, ERR_FLAGS}, 7'h00);
      RESET_N = 1'b1;
      cfg(1'b1, 16'h0000, 16'h0002, 16'h0000);
      cfg(1'b1, 16'h0001, 16'h0003, 16'h0000);
      cfg(1'b0, 16'h0000, 16'h0003, 16'h0000);
      cfg(1'b0, 16'h0001, 16'h0003, 16'h0001);
      cfg(1'b0, 16'h0002, 16'h0007, 16'h0001);
      // second doorbell replaces the first tail
      db(1'b0, 16'h0001, 16'h0001);
      db(1'b0, 16'h0001, 16'h0002);
      fetch_chk(16'h0001, 16'h0000);
      fetch_chk(16'h0001, 16'h0001);
      repeat (3) @(negedge REF_CLK);
      cmp(PAGE_LIST_USED, 1'b0);
      db(1'b0, 16'h0001, 16'h0000);
      fetch_chk(16'h0001, 16'h0002);
      fetch_chk(16'h0001, 16'h0003);
      repeat (3) @(negedge REF_CLK);
      cmp(PAGE_LIST_USED, 1'b1);
      // over-range tail and an unbuilt ring are refused
      db(1'b0, 16'h0001, 16'h0004);
      db(1'b0, 16'hFFFF, 16'h0000);
      repeat (3) @(negedge REF_CLK);
      cmp(fq.size(), 0);
      cmp(ERR_FLAGS, 4'h1);
      ERR_CLR = 4'h2;
      @(negedge REF_CLK);
      ERR_CLR = 4'h0;
      @(negedge REF_CLK);
      cmp(ERR_FLAGS, 4'h1);
      ERR_CLR = 4'h1;
      @(negedge REF_CLK);
      ERR_CLR = 4'h0;
      ERR_SET = 4'hF;
      @(negedge REF_CLK);
      ERR_SET = 4'h0;
      @(negedge REF_CLK);
      cmp(ERR_FLAGS, 4'h0);
      cpl(16'h0003, 16'h1234, 15'h0001);
      ERR_CLR = 4'hF;
      @(negedge REF_CLK);
      ERR_CLR = 4'h0;
      // random completions from three rings into two result rings, rings 1 and 2 sharing result ring 1
      repeat (40) begin
         slow = 1'($random(seed));
         k = $unsigned($random(seed)) % 3;
         cpl(k[15:0], 16'($random(seed)), 15'($random(seed)));
      end
      cmp(ERR_FLAGS, 4'h0);
      give_verdict();
   end
endmodule
